/* File: shared/sasp_pkg.sv */
// Constants shared by the converter sequencer: map, fields, resets, timing
package sasp_pkg;

	// Register byte addresses on the CPU bus
	localparam logic [15:0] SASP_ADDR_RESULT_LO = 16'hff08;
	localparam logic [15:0] SASP_ADDR_RESULT_HI = 16'hff09;
	localparam logic [15:0] SASP_ADDR_MODE = 16'hff28;
	localparam logic [15:0] SASP_ADDR_CHANNEL = 16'hff29;
	localparam logic [15:0] SASP_ADDR_CMP_MODE = 16'hff2a;
	localparam logic [15:0] SASP_ADDR_THRESHOLD = 16'hff2b;

	// Field positions in converter_mode_reg
	localparam int SASP_MODE_RUN_BIT = 7;
	localparam int SASP_MODE_TIME_LSB = 3;
	localparam int SASP_MODE_REF_BIT = 0;

	// Field positions in threshold_compare_mode
	localparam int SASP_CMP_EN_BIT = 7;
	localparam int SASP_CMP_POL_BIT = 6;

	// Field widths
	localparam int SASP_CHAN_W = 3;
	localparam int SASP_TIME_W = 3;
	localparam int SASP_RES_W = 10;
	localparam int SASP_RES_PAD = 6;
	localparam int SASP_SLOT_W = 5;

	// Values after reset
	localparam logic [7:0] SASP_RST_MODE = 8'h00;
	localparam logic [7:0] SASP_RST_CHANNEL = 8'h00;
	localparam logic [7:0] SASP_RST_CMP_MODE = 8'h00;
	localparam logic [7:0] SASP_RST_THRESHOLD = 8'h00;
	localparam logic [9:0] SASP_RST_RESULT = 10'h000;

	// Conversion-time codes
	localparam logic [2:0] SASP_TIME_288 = 3'h0;
	localparam logic [2:0] SASP_TIME_240 = 3'h1;
	localparam logic [2:0] SASP_TIME_192 = 3'h2;
	localparam logic [2:0] SASP_TIME_144 = 3'h4;
	localparam logic [2:0] SASP_TIME_120 = 3'h5;
	localparam logic [2:0] SASP_TIME_96 = 3'h6;

	// Whole conversion lengths in main clock periods
	localparam int SASP_CONV_CYC_288 = 288;
	localparam int SASP_CONV_CYC_240 = 240;
	localparam int SASP_CONV_CYC_192 = 192;
	localparam int SASP_CONV_CYC_144 = 144;
	localparam int SASP_CONV_CYC_120 = 120;
	localparam int SASP_CONV_CYC_96 = 96;

	// A conversion is split into equal slots: sampling, then one per bit
	localparam int SASP_SAMPLE_SLOTS = 2;
	localparam int SASP_CONV_SLOTS = SASP_SAMPLE_SLOTS + SASP_RES_W;

	// Comparator synchroniser depth; each slot must outlast it
	localparam int SASP_SYNC_STAGES = 2;

	// Starting bit of the approximation
	localparam logic [9:0] SASP_MSB_MASK = 10'h200;

endpackage

/* File: hdl/sasp_sync.sv */
// Two-flop synchroniser for levels from outside the clock domain
`timescale 1ns/1ps
module sasp_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// Level from another domain
	input wire logic [WIDTH-1:0] i_async,
	// Level in the clock domain
	output logic [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// Refuse a zero-width instance
	generate
		if (WIDTH < 1) begin : g_bad_width
			$error("sasp_sync needs WIDTH of at least one");
		end
	endgenerate

	// First stage feeds only the second stage
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule

/* File: hdl/sasp_sequencer.sv */
// Successive-approximation converter sequencer with threshold compare
//
// Behaviour
// RQ1: Channel code n routes analog input n.
// RQ2: Software writes zero to upper channel bits.
// RQ3: Reset clears channel, compare mode, threshold.
// RQ4: Result is 16 bits, low six zero.
// RQ5: High byte eight MSBs, low byte two.
// RQ6: Software reads result as one 16-bit access.
// RQ7: Software reads result before mode/channel writes.
// RQ8: Compare-mode bit 7 enables threshold compare.
// RQ9: Bit 6 picks at-least or below condition.
// RQ10: Threshold compared with eight result MSBs.
// RQ11: Sample fixed period, then hold to end.
// RQ12: Bit 9 tried first at half scale.
// RQ13: Each lower bit tried, cleared if below.
// RQ14: After ten bits latch result, raise event.
// RQ15: Conversions repeat back to back while running.
// RQ16: Register writes abort and restart a conversion.
// RQ17: Software waits 14 us after reference enable.
// RQ18: Restart needs settle wait if reference off.
// RQ19: Result is rounded ratio times 1024, times 64.
// RQ20: Register accesses insert one bus wait cycle.
// RQ21: Mode holds run, reference enable, time code.
// RQ22: Software discards first result without reference.
// RQ23: Cycle counting makes conversion the selected length.
// RQ24: Compare mode suppresses event, still stores result.
`timescale 1ns/1ps
module sasp_sequencer
	import sasp_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// CPU register access
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_wdata,
	output logic o_bus_wait,
	output logic [15:0] o_rdata,
	output logic o_rd_valid,
	// Analog front end
	output logic [2:0] o_channel_sel,
	output logic o_sample_hold,
	output logic [9:0] o_tap_code,
	input wire logic i_comp_ge,
	output logic o_ref_gen_enable,
	// Events and status
	output logic o_conversion_done_irq,
	output logic o_converting
);

	typedef enum logic [1:0] {
		SASP_IDLE,
		SASP_SAMPLE,
		SASP_CONVERT
	} sasp_state_t;

	// Slot length per time code; a whole conversion is twelve slots
	function automatic logic [SASP_SLOT_W-1:0] slot_len(
		input logic [SASP_TIME_W-1:0] code
	);
		logic [SASP_SLOT_W-1:0] len;
		case (code)
			SASP_TIME_288: len = SASP_SLOT_W'(SASP_CONV_CYC_288 / SASP_CONV_SLOTS);
			SASP_TIME_240: len = SASP_SLOT_W'(SASP_CONV_CYC_240 / SASP_CONV_SLOTS);
			SASP_TIME_192: len = SASP_SLOT_W'(SASP_CONV_CYC_192 / SASP_CONV_SLOTS);
			SASP_TIME_144: len = SASP_SLOT_W'(SASP_CONV_CYC_144 / SASP_CONV_SLOTS);
			SASP_TIME_120: len = SASP_SLOT_W'(SASP_CONV_CYC_120 / SASP_CONV_SLOTS);
			SASP_TIME_96: len = SASP_SLOT_W'(SASP_CONV_CYC_96 / SASP_CONV_SLOTS);
			// Prohibited codes fall back to the slowest, safest pace
			default: len = SASP_SLOT_W'(SASP_CONV_CYC_288 / SASP_CONV_SLOTS);
		endcase
		return len;
	endfunction

	// Shortest slot must leave time for the comparator synchroniser
	generate
		if (SASP_CONV_CYC_96 / SASP_CONV_SLOTS <= SASP_SYNC_STAGES + 1) begin : g_bad_slot
			$error("conversion slot too short for comparator latency");
		end
		if (SASP_CONV_CYC_288 / SASP_CONV_SLOTS >= (1 << SASP_SLOT_W)) begin : g_bad_cnt
			$error("slot counter too narrow");
		end
	endgenerate

	// Register state
	logic mode_run_q;
	logic [SASP_TIME_W-1:0] mode_time_q;
	logic mode_ref_q;
	logic [SASP_CHAN_W-1:0] chan_q;
	logic cmp_en_q;
	logic cmp_pol_q;
	logic [7:0] thresh_q;
	logic [SASP_RES_W-1:0] result_q;
	logic [SASP_RES_W-1:0] result_d;
	logic result_we;

	// Bus handshake state
	logic wait_q;
	logic [15:0] rdata_q;
	logic rd_valid_q;

	// Sequencer state
	sasp_state_t state_q;
	sasp_state_t state_d;
	logic [SASP_SLOT_W-1:0] slot_cnt_q;
	logic [SASP_SLOT_W-1:0] slot_cnt_d;
	logic [1:0] samp_slot_q;
	logic [1:0] samp_slot_d;
	logic [SASP_RES_W-1:0] mask_q;
	logic [SASP_RES_W-1:0] mask_d;
	logic [SASP_RES_W-1:0] sar_q;
	logic [SASP_RES_W-1:0] sar_d;
	logic done_q;
	logic done_d;

	// Address decode
	wire hit_res_lo = (i_addr == SASP_ADDR_RESULT_LO);
	wire hit_res_hi = (i_addr == SASP_ADDR_RESULT_HI);
	wire hit_mode = (i_addr == SASP_ADDR_MODE);
	wire hit_chan = (i_addr == SASP_ADDR_CHANNEL);
	wire hit_cmp = (i_addr == SASP_ADDR_CMP_MODE);
	wire hit_thr = (i_addr == SASP_ADDR_THRESHOLD);
	wire hit_any = hit_res_lo | hit_res_hi | hit_mode | hit_chan | hit_cmp |
		hit_thr;

	// One wait cycle per access; action happens in the second cycle
	wire acc = (i_rd | i_wr) & hit_any;
	wire take = acc & wait_q;
	wire wr_take = take & i_wr;
	wire rd_take = take & i_rd & ~i_wr;
	assign o_bus_wait = acc & ~wait_q; // see RQ20

	// Write strobes per register
	wire wr_mode = wr_take & hit_mode;
	wire wr_chan = wr_take & hit_chan;
	wire wr_cmp = wr_take & hit_cmp;
	wire wr_thr = wr_take & hit_thr;
	wire wr_any = wr_mode | wr_chan | wr_cmp | wr_thr;
	wire new_run = wr_mode ? i_wdata[SASP_MODE_RUN_BIT] : mode_run_q;

	// Comparator level crosses in from the analog side
	logic comp_ge_s;
	sasp_sync #(
		.WIDTH(1)
	) u_comp_sync (
		.i_ref_clk(i_ref_clk),
		.i_resetn(i_resetn),
		.i_async(i_comp_ge),
		.o_sync(comp_ge_s)
	);

	// Slot timing and bit decisions
	wire [SASP_SLOT_W-1:0] slot_last = slot_len(mode_time_q) -
		SASP_SLOT_W'(1);
	wire slot_end = (slot_cnt_q == slot_last); // see RQ23
	wire samp_done = (samp_slot_q == 2'(SASP_SAMPLE_SLOTS - 1));
	wire [SASP_RES_W-1:0] decided = comp_ge_s ? sar_q : (sar_q & ~mask_q);

	// Threshold test on the eight MSBs of the fresh result
	wire [7:0] top_byte = decided[SASP_RES_W-1:SASP_RES_W-8]; // see RQ10
	wire cond_ge = (top_byte >= thresh_q);
	wire cond_lt = (top_byte < thresh_q);
	wire cond_met = cmp_pol_q ? cond_lt : cond_ge; // see RQ9
	wire irq_ok = ~cmp_en_q | cond_met; // see RQ8, see RQ24

	// Read data; unused high bits of byte registers read as zero
	wire [15:0] res_word = {result_q, SASP_RES_PAD'(0)}; // see RQ4, see RQ19
	wire [15:0] mode_byte = {8'h00, mode_run_q, 1'b0, mode_time_q, 2'b00,
		mode_ref_q};
	wire [15:0] chan_byte = {8'h00, 5'h00, chan_q};
	wire [15:0] cmp_byte = {8'h00, cmp_en_q, cmp_pol_q, 6'h00};
	wire [15:0] thr_byte = {8'h00, thresh_q};
	wire [15:0] res_hi_byte = {8'h00, res_word[15:8]}; // see RQ5
	wire [15:0] rd_mux = hit_res_lo ? res_word :
		hit_res_hi ? res_hi_byte :
		hit_mode ? mode_byte :
		hit_chan ? chan_byte :
		hit_cmp ? cmp_byte :
		thr_byte;

	// Bus wait and read capture
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			wait_q <= 1'b0;
			rdata_q <= 16'h0000;
			rd_valid_q <= 1'b0;
		end else begin
			wait_q <= acc & ~wait_q;
			rd_valid_q <= rd_take;
			if (rd_take) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// Converter mode register: run, time code, reference enable
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			mode_run_q <= SASP_RST_MODE[SASP_MODE_RUN_BIT];
			mode_time_q <= SASP_RST_MODE[SASP_MODE_TIME_LSB +: SASP_TIME_W];
			mode_ref_q <= SASP_RST_MODE[SASP_MODE_REF_BIT];
		end else if (wr_mode) begin
			mode_run_q <= i_wdata[SASP_MODE_RUN_BIT]; // see RQ21
			mode_time_q <= i_wdata[SASP_MODE_TIME_LSB +: SASP_TIME_W];
			mode_ref_q <= i_wdata[SASP_MODE_REF_BIT];
		end
	end

	// Channel, compare mode and threshold registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			chan_q <= SASP_RST_CHANNEL[SASP_CHAN_W-1:0]; // see RQ3
			cmp_en_q <= SASP_RST_CMP_MODE[SASP_CMP_EN_BIT];
			cmp_pol_q <= SASP_RST_CMP_MODE[SASP_CMP_POL_BIT];
			thresh_q <= SASP_RST_THRESHOLD;
		end else begin
			// Upper channel bits are not stored; software keeps them zero
			if (wr_chan) begin
				chan_q <= i_wdata[SASP_CHAN_W-1:0]; // see RQ2
			end
			if (wr_cmp) begin
				cmp_en_q <= i_wdata[SASP_CMP_EN_BIT];
				cmp_pol_q <= i_wdata[SASP_CMP_POL_BIT];
			end
			if (wr_thr) begin
				thresh_q <= i_wdata;
			end
		end
	end

	// Sequencer next state
	always_comb begin
		state_d = state_q;
		slot_cnt_d = slot_cnt_q;
		samp_slot_d = samp_slot_q;
		mask_d = mask_q;
		sar_d = sar_q;
		done_d = 1'b0;
		result_we = 1'b0;
		result_d = decided;
		if (wr_any) begin
			// A write to mode, channel, compare mode or threshold throws the running conversion away
			state_d = new_run ? SASP_SAMPLE : SASP_IDLE; // see RQ16
			slot_cnt_d = '0;
			samp_slot_d = 2'b00;
			mask_d = SASP_MSB_MASK;
			sar_d = '0;
		end else begin
			case (state_q)
				SASP_IDLE: begin
					slot_cnt_d = '0;
					samp_slot_d = 2'b00;
					mask_d = SASP_MSB_MASK;
					sar_d = '0;
					if (mode_run_q) begin
						state_d = SASP_SAMPLE;
					end
				end
				SASP_SAMPLE: begin
					slot_cnt_d = slot_cnt_q + SASP_SLOT_W'(1);
					if (slot_end) begin
						slot_cnt_d = '0;
						if (samp_done) begin
							// Hold from here; try bit 9 at half scale
							state_d = SASP_CONVERT; // see RQ11
							sar_d = SASP_MSB_MASK; // see RQ12
							mask_d = SASP_MSB_MASK;
						end else begin
							samp_slot_d = samp_slot_q + 2'b01;
						end
					end
				end
				SASP_CONVERT: begin
					slot_cnt_d = slot_cnt_q + SASP_SLOT_W'(1);
					if (slot_end) begin
						slot_cnt_d = '0;
						if (mask_q[0]) begin
							// Last bit decided: store, signal, start again
							result_we = 1'b1; // see RQ14
							done_d = irq_ok; // see RQ24
							state_d = SASP_SAMPLE; // see RQ15
							samp_slot_d = 2'b00;
							mask_d = SASP_MSB_MASK;
							sar_d = '0;
						end else begin
							// Keep decided bits, try the next one down
							mask_d = mask_q >> 1; // see RQ13
							sar_d = decided | (mask_q >> 1);
						end
					end
				end
				default: begin
					state_d = SASP_IDLE;
				end
			endcase
		end
	end

	// Sequencer registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			state_q <= SASP_IDLE;
			slot_cnt_q <= '0;
			samp_slot_q <= 2'b00;
			mask_q <= SASP_MSB_MASK;
			sar_q <= '0;
			done_q <= 1'b0;
		end else begin
			state_q <= state_d;
			slot_cnt_q <= slot_cnt_d;
			samp_slot_q <= samp_slot_d;
			mask_q <= mask_d;
			sar_q <= sar_d;
			done_q <= done_d;
		end
	end

	// Result latch; reset value is a convenience, software must not rely on it
	always_ff @(posedge i_ref_clk) begin
		if (!i_resetn) begin
			result_q <= SASP_RST_RESULT;
		end else if (result_we) begin
			result_q <= result_d; // see RQ14
		end
	end

	// Outputs
	assign o_rdata = rdata_q;
	assign o_rd_valid = rd_valid_q;
	assign o_channel_sel = chan_q; // see RQ1
	assign o_sample_hold = (state_q == SASP_SAMPLE); // see RQ11
	assign o_tap_code = sar_q; // see RQ13
	assign o_ref_gen_enable = mode_ref_q; // see RQ21
	assign o_conversion_done_irq = done_q;
	assign o_converting = (state_q != SASP_IDLE);

endmodule

/* File: testbench/sasp_seq_chk.sv */
// Port assertions for the converter sequencer
`timescale 1ns/1ps
module sasp_seq_chk
	import sasp_pkg::*;
(
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_resetn,
	// CPU register access
	input wire logic [15:0] i_addr,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [7:0] i_wdata,
	input wire logic o_bus_wait,
	input wire logic [15:0] o_rdata,
	input wire logic o_rd_valid,
	// Front end and events
	input wire logic [2:0] o_channel_sel,
	input wire logic o_sample_hold,
	input wire logic [9:0] o_tap_code,
	input wire logic o_ref_gen_enable,
	input wire logic o_conversion_done_irq,
	input wire logic o_converting
);
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_resetn);
	// Mapped: ff08/ff09 and ff28..ff2b
	logic hit;
	logic req;
	logic wd0;
	assign hit = (i_addr[15:1] == 15'h7f84) || (i_addr[15:2] == 14'h3fca);
	assign req = i_rd || i_wr;
	assign wd0 = i_wdata[0];
	property p_wait_once;
		o_bus_wait |=> !o_bus_wait;
	endproperty
	a_wait_once: assert property (p_wait_once)
		else $error("bus wait longer than one cycle");
	property p_wait_start;
		req && hit && !$past(req) |-> o_bus_wait;
	endproperty
	a_wait_start: assert property (p_wait_start)
		else $error("no bus wait on mapped access");
	property p_rd_answer;
		o_bus_wait && i_rd && !i_wr |=> !o_rd_valid ##1 o_rd_valid;
	endproperty
	a_rd_answer: assert property (p_rd_answer)
		else $error("read answer late or early");
	property p_res_lo;
		o_rd_valid && $past(i_addr, 2) == SASP_ADDR_RESULT_LO
			|-> o_rdata[5:0] == 6'h00;
	endproperty
	a_res_lo: assert property (p_res_lo)
		else $error("result low bits not zero");
	property p_chan;
		o_bus_wait && i_wr && i_addr == SASP_ADDR_CHANNEL
			|-> ##2 {5'h00, o_channel_sel} == $past(i_wdata, 2);
	endproperty
	a_chan: assert property (p_chan)
		else $error("channel select not updated");
	property p_stop;
		o_bus_wait && i_wr && i_addr == SASP_ADDR_MODE && !i_wdata[7]
			|-> ##2 !o_converting && o_ref_gen_enable == $past(wd0, 2);
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop write not obeyed");
	property p_irq_pulse;
		o_conversion_done_irq |=> !o_conversion_done_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("done event longer than one cycle");
	property p_sample_len;
		$rose(o_sample_hold) |-> (o_sample_hold || !o_converting)[*8];
	endproperty
	a_sample_len: assert property (p_sample_len)
		else $error("sampling too short");
	property p_msb_first;
		$fell(o_sample_hold) && o_converting |-> o_tap_code == SASP_MSB_MASK;
	endproperty
	a_msb_first: assert property (p_msb_first)
		else $error("first tap not half scale");
	property p_reset;
		$rose(i_resetn) |-> o_channel_sel == 3'h0 && !o_converting;
	endproperty
	a_reset: assert property (p_reset)
		else $error("state not cleared by reset");
	// Main scenarios reached
	c_irq: cover property (o_conversion_done_irq);
	c_read: cover property (o_rd_valid);
	c_hold: cover property ($fell(o_sample_hold));
endmodule
bind sasp_sequencer sasp_seq_chk i_sasp_seq_chk (.i_ref_clk, .i_resetn,
	.i_addr, .i_wr, .i_rd, .i_wdata, .o_bus_wait, .o_rdata, .o_rd_valid,
	.o_channel_sel, .o_sample_hold, .o_tap_code, .o_ref_gen_enable,
	.o_conversion_done_irq, .o_converting);

/* File: testbench/sasp_analog_model.sv */
// Analog side: eight input levels, sample-and-hold and comparator
`timescale 1ns/1ps
module sasp_analog_model #(
	parameter logic [7:0][9:0] LVL = '0
) (
	// Front-end controls
	input wire logic [2:0] i_channel_sel,
	input wire logic i_sample_hold,
	input wire logic [9:0] i_tap_code,
	// Comparator
	output logic o_comp_ge
);
	logic [9:0] held = 10'h000;
	// Track while sampling, freeze on hold so mux changes cannot leak in
	always @* begin
		if (i_sample_hold)
			held = LVL[i_channel_sel];
	end
	// Ideal comparator, no offset: levels land exactly on codes
	assign o_comp_ge = (held >= i_tap_code);
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench for the converter sequencer
`timescale 1ns/1ps
module tb_top
	import sasp_pkg::*;
;
	localparam logic [7:0][9:0] LVL = {10'h37c, 10'h0c3, 10'h2aa, 10'h155,
		10'h1ff, 10'h200, 10'h000, 10'h3ff};
	logic i_ref_clk, i_resetn, i_wr, i_rd, i_comp_ge, w, v;
	logic o_bus_wait, o_rd_valid, o_sample_hold, o_ref_gen_enable;
	logic o_conversion_done_irq, o_converting;
	logic [15:0] i_addr, o_rdata, d;
	logic [7:0] i_wdata;
	logic [2:0] o_channel_sel;
	logic [9:0] o_tap_code;
	int bad_count = 0;
	int check_count = 0;
	int cycles = 0;
	int n;
	// Last entry is a prohibited code, expected at the slowest pace
	logic [2:0] tc [7] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
	int nc [7] = '{288, 240, 192, 144, 120, 96, 288};
	sasp_sequencer i_sasp_sequencer (.i_ref_clk, .i_resetn, .i_addr, .i_wr,
		.i_rd, .i_wdata, .o_bus_wait, .o_rdata, .o_rd_valid, .o_channel_sel,
		.o_sample_hold, .o_tap_code, .i_comp_ge, .o_ref_gen_enable,
		.o_conversion_done_irq, .o_converting);
	sasp_analog_model #(.LVL(LVL)) i_sasp_analog_model (
		.i_channel_sel(o_channel_sel), .i_sample_hold(o_sample_hold),
		.i_tap_code(o_tap_code), .o_comp_ge(i_comp_ge));
	// 50 MHz clock
	initial begin
		i_ref_clk = 1'b0;
		forever #10 i_ref_clk = ~i_ref_clk;
	end
	// Hang guard, well above the planned run length
	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 10000) begin
			bad_count++;
			finish_test();
		end
	end
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// One access: request held over the wait cycle, dropped after taking
	task automatic acc(input logic r, input logic [15:0] a,
		input logic [7:0] wd);
		@(posedge i_ref_clk);
		#1;
		i_rd = r;
		i_wr = !r;
		i_addr = a;
		i_wdata = wd;
		#1;
		w = o_bus_wait;
		repeat (2) @(posedge i_ref_clk);
		#1;
		v = o_rd_valid;
		d = o_rdata;
		i_rd = 1'b0;
		i_wr = 1'b0;
	endtask
	// Cycles until the done event, 0 if none within lim
	task automatic wirq(input int lim);
		n = 0;
		for (int k = 1; k <= lim && n == 0; k++) begin
			@(posedge i_ref_clk);
			#1;
			if (o_conversion_done_irq === 1'b1)
				n = k;
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		i_resetn = 1'b0;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_addr = 16'h0000;
		i_wdata = 8'h00;
		repeat (3) @(posedge i_ref_clk);
		#1;
		i_resetn = 1'b1;
		for (int a = 0; a < 4; a++) begin
			acc(1'b1, SASP_ADDR_MODE + 16'(a), 8'h00);
			chk("reset value", 16'h0000, d);
		end
		acc(1'b1, 16'hff2c, 8'h00);
		chk("unmapped", 16'h0000, {14'h0000, w, v});
		acc(1'b0, SASP_ADDR_THRESHOLD, 8'ha5);
		acc(1'b1, SASP_ADDR_THRESHOLD, 8'h00);
		chk("handshake", 16'h0003, {14'h0000, w, v});
		chk("threshold", 16'h00a5, d);
		// Reference on, settle before running
		acc(1'b0, SASP_ADDR_MODE, 8'h01);
		repeat (700) @(posedge i_ref_clk);
		// Every conversion-time code, stopping before each change
		for (int i = 0; i < 7; i++) begin
			acc(1'b0, SASP_ADDR_MODE, {2'b10, tc[i], 3'b001});
			wirq(1000);
			chk("first event", 16'(nc[i]), 16'(n));
			wirq(1000);
			chk("period", 16'(nc[i]), 16'(n));
			acc(1'b0, SASP_ADDR_MODE, 8'h01);
			chk("stopped", 16'h0001, {14'h0000, o_converting,
				o_ref_gen_enable});
		end
		// Each channel, written mid-conversion, result read before next write
		acc(1'b0, SASP_ADDR_MODE, 8'hb1);
		for (int c = 0; c < 8; c++) begin
			acc(1'b0, SASP_ADDR_CHANNEL, 8'(c));
			chk("channel", 16'(c), 16'(o_channel_sel));
			wirq(300);
			chk("restart", 16'h0060, 16'(n));
			acc(1'b1, SASP_ADDR_RESULT_LO, 8'h00);
			chk("result", {LVL[c], 6'h00}, d);
			acc(1'b1, SASP_ADDR_RESULT_HI, 8'h00);
			chk("result high", {8'h00, LVL[c][9:2]}, d);
		end
		// Both polarities at and one above the upper result byte
		for (int j = 0; j < 4; j++) begin
			acc(1'b0, SASP_ADDR_CMP_MODE, {1'b1, j[1], 6'h00});
			acc(1'b0, SASP_ADDR_THRESHOLD, LVL[7][9:2] + 8'(j[0]));
			wirq(300);
			chk("gated event", (j[1] ^ j[0]) ? 16'h0000 : 16'h0060,
				16'(n));
			acc(1'b1, SASP_ADDR_RESULT_LO, 8'h00);
			chk("gated result", {LVL[7], 6'h00}, d);
		end
		acc(1'b0, SASP_ADDR_MODE, 8'h00);
		chk("ref off", 16'h0000, {15'h0000, o_ref_gen_enable});
		// Reset after real writes must clear them again
		@(posedge i_ref_clk);
		#1;
		i_resetn = 1'b0;
		repeat (3) @(posedge i_ref_clk);
		#1;
		i_resetn = 1'b1;
		for (int a = 0; a < 4; a++) begin
			acc(1'b1, SASP_ADDR_MODE + 16'(a), 8'h00);
			chk("reset again", 16'h0000, d);
		end
		finish_test();
	end
endmodule
